// [rtl/geg_pkg.sv]
package geg_pkg;
  // ==========================================================
  // Sizes and reset values
  localparam int VEC_COUNT = 256;
  localparam int VEC_W = 8;
  localparam logic [255:0] MASK_RESET = {256{1'b1}};
  localparam int MASK_WORDS = 8;
  localparam int WORD_W = 32;
  localparam logic [31:0] INIT_FETCH_ADDR = 32'h0ffffff0;

  // ==========================================================
  // Guest exit codes
  typedef enum logic [1:0] {
    GEG_EXIT_NONE,
    GEG_EXIT_INIT,
    GEG_EXIT_NMI,
    GEG_EXIT_SMI
  } geg_exit_e;

  // ==========================================================
  // Actions taken by the core on an event
  typedef enum logic [2:0] {
    GEG_ACT_NONE,
    GEG_ACT_INIT,
    GEG_ACT_SECEXC,
    GEG_ACT_NMI,
    GEG_ACT_SMI
  } geg_act_e;
endpackage

// [rtl/geg_prio.sv]
`timescale 1ns/1ps
`default_nettype none
module geg_prio (
  geg_vec_if.prio vi // Pending and mask in, winner out
);
  import geg_pkg::*;
  // ==========================================================
  // Highest enabled pending vector wins
  always_comb begin
    vi.valid = 1'b0;
    vi.vector = 8'h00;
    for (int i = 0; i < VEC_COUNT; i++) begin
      if (vi.pending[i] && vi.mask[i]) begin
        vi.valid = 1'b1;
        vi.vector = VEC_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/geg_top.sv]
`timescale 1ns/1ps
`default_nettype none
module geg_top (
  input wire logic ref_clk, // Core clock
  input wire logic rst_n, // Async reset
  input wire logic init_pin, // INIT pin, async
  input wire logic init_msg, // INIT message pulse
  input wire logic nmi_pin, // NMI pin, async
  input wire logic ext_smi_pin, // External MGMT_INTERRUPT pin, async
  input wire logic io_smi_trap, // Internal trap pulse with I/O instr
  input wire logic insn_boundary, // Instruction boundary pulse
  input wire logic in_guest, // Guest running
  input wire logic global_event_flag, // Global flag
  input wire logic init_intercept, // INIT intercept control
  input wire logic init_redirect, // Redirect bit of virt_control_reg
  input wire logic nmi_intercept, // NMI intercept control
  input wire logic smi_intercept, // MGMT_INTERRUPT intercept control
  input wire logic intr_req, // Maskable interrupt request
  input wire logic vintr_req, // Virtual interrupt request
  input wire logic mgmt_lock_bit, // Firmware lock in hw_config_reg
  input wire logic ctl_wr, // Write to mgmt_mode_control_reg
  input wire logic base_wr, // Write to mgmt_mode_base_reg
  input wire logic [31:0] ctl_wdata, // Write data
  input wire logic mgmt_resume_instr, // Resume from management mode
  input wire logic apic_we, // Mask page write
  input wire logic apic_re, // Mask page read
  input wire logic [2:0] apic_word, // Mask word index
  input wire logic [31:0] apic_wdata, // Mask write data
  input wire logic [255:0] irq_pend_set, // Vectors becoming pending
  input wire logic eoi_valid, // Specific end-of-interrupt
  input wire logic [7:0] eoi_vector, // Vector to clear
  input wire logic ack, // Core accepts winner
  output logic [31:0] apic_rdata, // Mask read data
  output logic irq_valid, // Enabled pending vector exists
  output logic [7:0] irq_vector, // Winning vector
  output logic [255:0] in_service, // In-service vectors
  output geg_pkg::geg_exit_e exit_code, // Guest exit code, pulse
  output geg_pkg::geg_act_e action, // Taken event, pulse
  output logic [31:0] fetch_addr, // Fetch address after INIT
  output logic reinit_regs, // Reinit control/seg/GP regs
  output logic mem_ctl_notify, // Memory controller signal
  output logic gp_fault, // Protection fault pulse
  output logic [31:0] mgmt_mode_control_reg, // Control register
  output logic [31:0] mgmt_mode_base_reg, // Base register
  output logic in_mgmt_mode, // In management mode
  output logic guest_ctx_smi, // MGMT_INTERRUPT taken in guest context
  output logic mgmt_memory_region, // Region mapped
  output logic intr_take, // Maskable interrupt taken
  output logic vintr_take, // Virtual interrupt taken
  output logic [2:0] pend_flags // {ext smi, nmi, init}
);
  import geg_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // Third flop keeps the last level for the edge detect
  logic [1:0] init_s, nmi_s, smi_s;
  logic init_q, nmi_q, smi_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_s <= 2'h0;
      nmi_s <= 2'h0;
      smi_s <= 2'h0;
      init_q <= 1'b0;
      nmi_q <= 1'b0;
      smi_q <= 1'b0;
    end else begin
      init_s <= {init_s[0], init_pin};
      nmi_s <= {nmi_s[0], nmi_pin};
      smi_s <= {smi_s[0], ext_smi_pin};
      init_q <= init_s[1];
      nmi_q <= nmi_s[1];
      smi_q <= smi_s[1];
    end
  end
  logic init_arr, nmi_arr, smi_arr;
  assign init_arr = (init_s[1] & ~init_q) | init_msg;
  assign nmi_arr = nmi_s[1] & ~nmi_q;
  assign smi_arr = smi_s[1] & ~smi_q;

  // ==========================================================
  // Event decision at instruction boundary, on an I/O trap, or on a flag rise with SMI pending
  logic init_p, nmi_p, smi_p, flag_q;
  logic init_clr, nmi_clr, smi_clr, exit_ev, init_take;
  logic smi_take, set_global_flag_instr_smi;
  geg_exit_e next_exit;
  geg_act_e next_act;
  assign set_global_flag_instr_smi = global_event_flag & ~flag_q & smi_p;
  always_comb begin
    next_exit = GEG_EXIT_NONE;
    next_act = GEG_ACT_NONE;
    init_clr = 1'b0;
    nmi_clr = 1'b0;
    smi_clr = 1'b0;
    if (global_event_flag && !in_mgmt_mode) begin
      // Trap is never latched, so it is lost with the flag clear
      if (io_smi_trap) begin
        if (smi_intercept && in_guest) begin
          next_exit = GEG_EXIT_SMI;
        end else begin
          next_act = GEG_ACT_SMI;
        end
      end else if (set_global_flag_instr_smi) begin
        next_act = GEG_ACT_SMI;
        smi_clr = 1'b1;
      end else if (insn_boundary) begin
        if (smi_p) begin
          if (smi_intercept && in_guest) begin
            next_exit = GEG_EXIT_SMI;
          end else begin
            next_act = GEG_ACT_SMI;
            smi_clr = 1'b1;
          end
        end else if (init_p) begin
          if (init_intercept && in_guest) begin
            next_exit = GEG_EXIT_INIT;
          end else if (init_redirect) begin
            next_act = GEG_ACT_SECEXC;
            init_clr = 1'b1;
          end else begin
            next_act = GEG_ACT_INIT;
            init_clr = 1'b1;
          end
        end else if (nmi_p) begin
          if (nmi_intercept && in_guest) begin
            next_exit = GEG_EXIT_NMI;
          end else begin
            next_act = GEG_ACT_NMI;
            nmi_clr = 1'b1;
          end
        end
      end
    end
  end
  assign exit_ev = next_exit != GEG_EXIT_NONE;
  assign init_take = next_act == GEG_ACT_INIT;
  assign smi_take = next_act == GEG_ACT_SMI;

  // ==========================================================
  // Pending latches, arrival wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_p <= 1'b0;
      nmi_p <= 1'b0;
      smi_p <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      init_p <= init_arr | (init_p & ~init_clr);
      nmi_p <= nmi_arr | (nmi_p & ~nmi_clr);
      smi_p <= smi_arr | (smi_p & ~smi_clr);
      flag_q <= global_event_flag;
    end
  end

  // ==========================================================
  // Event outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exit_code <= GEG_EXIT_NONE;
      action <= GEG_ACT_NONE;
      fetch_addr <= INIT_FETCH_ADDR;
      reinit_regs <= 1'b0;
      mem_ctl_notify <= 1'b0;
      pend_flags <= 3'h0;
    end else begin
      exit_code <= next_exit;
      action <= next_act;
      reinit_regs <= init_take;
      if (init_take) begin
        fetch_addr <= INIT_FETCH_ADDR;
      end
      mem_ctl_notify <= 1'b0;
      pend_flags <= {smi_p, nmi_p, init_p};
    end
  end

  // ==========================================================
  // Interrupt gating, only in cycles with no event decided
  logic ev_idle;
  assign ev_idle = global_event_flag & ~exit_ev & (next_act == GEG_ACT_NONE);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intr_take <= 1'b0;
      vintr_take <= 1'b0;
    end else begin
      intr_take <= intr_req & ev_idle;
      vintr_take <= vintr_req & ev_idle & ~intr_req;
    end
  end

  // ==========================================================
  // Management mode state and controls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_mgmt_mode <= 1'b0;
      guest_ctx_smi <= 1'b0;
      mgmt_memory_region <= 1'b0;
    end else begin
      if (smi_take) begin
        in_mgmt_mode <= 1'b1;
        guest_ctx_smi <= in_guest;
        mgmt_memory_region <= 1'b1;
      end else if (mgmt_resume_instr && in_mgmt_mode) begin
        in_mgmt_mode <= 1'b0;
        guest_ctx_smi <= 1'b0;
        mgmt_memory_region <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_fault <= 1'b0;
    end else begin
      gp_fault <= ctl_wr & mgmt_lock_bit;
    end
  end

  // Locked registers ignore writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_mode_control_reg <= 32'h00000000;
    end else if (ctl_wr && !mgmt_lock_bit) begin
      mgmt_mode_control_reg <= ctl_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_mode_base_reg <= 32'h00000000;
    end else if (base_wr && !mgmt_lock_bit) begin
      mgmt_mode_base_reg <= ctl_wdata;
    end
  end

  // ==========================================================
  // Vector mask, pending and in-service
  logic [255:0] vector_enable_mask, irr;
  geg_vec_if vi ();
  geg_prio u_prio (
    .vi(vi)
  );
  assign vi.pending = irr;
  assign vi.mask = vector_enable_mask;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_enable_mask <= MASK_RESET;
    end else if (apic_we) begin
      vector_enable_mask[apic_word*WORD_W +: WORD_W] <= apic_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      apic_rdata <= 32'h00000000;
    end else if (apic_re) begin
      apic_rdata <= vector_enable_mask[apic_word*WORD_W +: WORD_W];
    end
  end

  // Named end-of-interrupt clears its vector in any order
  logic [255:0] eoi_hot, ack_hot;
  assign eoi_hot = eoi_valid ? (256'h1 << eoi_vector) : 256'h0;
  assign ack_hot = (ack && vi.valid) ? (256'h1 << vi.vector) : 256'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irr <= 256'h0;
      in_service <= 256'h0;
      irq_valid <= 1'b0;
      irq_vector <= 8'h00;
    end else begin
      irr <= irq_pend_set | (irr & ~eoi_hot & ~ack_hot);
      in_service <= ack_hot | (in_service & ~eoi_hot);
      irq_valid <= vi.valid;
      irq_vector <= vi.vector;
    end
  end
endmodule
`default_nettype wire

// [rtl/geg_vec_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface geg_vec_if;
  logic [255:0] pending;
  logic [255:0] mask;
  logic valid;
  logic [7:0] vector;
  modport prio (input pending, input mask, output valid, output vector);
  modport core (output pending, output mask, input valid, input vector);
endinterface
`default_nettype wire

// [tb/geg_src.sv]
`timescale 1ns/1ps
`default_nettype none
module geg_src (
  input wire logic ref_clk, // Clock
  input wire logic [2:0] fire, // {smi, nmi, init} request
  output logic [2:0] pins // {smi, nmi, init} levels
);
  // Platform pins move with skew, 1.3 ns after the rising edge
  always @(posedge ref_clk) pins <= #1.3 fire;
endmodule
`default_nettype wire

// [tb/geg_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Event gating checks
module geg_top_asserts
  import geg_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic io_smi_trap, // Trap
  input wire logic in_guest, // Guest
  input wire logic global_event_flag, // Flag
  input wire logic init_redirect, // Redirect
  input wire logic smi_intercept, // Intercept
  input wire logic in_mgmt_mode, // Mode
  input wire logic mgmt_lock_bit, // Lock
  input wire logic ctl_wr, // Write
  input wire logic [31:0] mgmt_mode_control_reg, // Control
  input wire logic gp_fault, // Fault
  input wire logic mem_ctl_notify, // Notify
  input wire logic intr_take, // Intr
  input wire logic vintr_take, // Virtual intr
  input wire logic [31:0] fetch_addr, // Fetch
  input wire logic reinit_regs, // Reinit
  input var geg_pkg::geg_exit_e exit_code, // Exit
  input var geg_pkg::geg_act_e action // Action
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_mem_quiet: assert property (mem_ctl_notify == 1'b0)
    else $error("memory controller signalled");
  a_init_fetch: assert property (action == GEG_ACT_INIT |->
    reinit_regs && fetch_addr == INIT_FETCH_ADDR) else $error("bad init");
  a_flag_gates: assert property (!global_event_flag |=>
    {exit_code, action} == 5'h0) else $error("event with flag clear");
  a_flag_intr: assert property (!global_event_flag |=> !intr_take)
    else $error("interrupt with flag clear");
  a_flag_vintr: assert property (!global_event_flag |=> !vintr_take)
    else $error("virtual interrupt with flag clear");
  a_sec_cause: assert property (action == GEG_ACT_SECEXC |-> $past(init_redirect))
    else $error("security exception without redirect");
  a_exit_guest: assert property (exit_code != GEG_EXIT_NONE |-> $past(in_guest))
    else $error("exit outside guest");
  a_lock_fault: assert property (ctl_wr && mgmt_lock_bit |=>
    gp_fault && $stable(mgmt_mode_control_reg)) else $error("locked write");
  a_trap_exit: assert property (io_smi_trap && global_event_flag && in_guest &&
    smi_intercept && !in_mgmt_mode |=> exit_code == GEG_EXIT_SMI) else $error("trap no exit");
  c_sec: cover property (action == GEG_ACT_SECEXC);
  c_init_exit: cover property (exit_code == GEG_EXIT_INIT);
  c_smi: cover property (action == GEG_ACT_SMI);
  c_nmi_exit: cover property (exit_code == GEG_EXIT_NMI);
endmodule

bind geg_top geg_top_asserts u_geg_top_asserts (.ref_clk, .rst_n, .io_smi_trap, .in_guest,
  .global_event_flag, .init_redirect, .smi_intercept, .in_mgmt_mode, .mgmt_lock_bit, .ctl_wr,
  .mgmt_mode_control_reg, .gp_fault, .mem_ctl_notify, .intr_take, .vintr_take, .fetch_addr,
  .reinit_regs, .exit_code, .action);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import geg_pkg::*;
  logic ref_clk, rst_n, init_msg, io_smi_trap, insn_boundary, in_guest, global_event_flag;
  logic init_intercept, init_redirect, nmi_intercept, smi_intercept, mgmt_lock_bit, ctl_wr;
  logic apic_we, apic_re, eoi_valid, irq_valid, intr_req, vintr_req, base_wr, ack;
  logic mgmt_resume_instr, intr_take, vintr_take, gp_fault, in_mgmt_mode, guest_ctx_smi;
  logic mgmt_memory_region;
  logic [2:0] fire, pins, apic_word, pend_flags;
  logic [7:0] eoi_vector, irq_vector;
  logic [31:0] ctl_wdata, apic_wdata, apic_rdata, fetch_addr, mgmt_mode_control_reg, ev;
  logic [255:0] irq_pend_set, in_service;
  logic [31:0] mgmt_mode_base_reg;
  geg_exit_e exit_code;
  geg_act_e action;
  int fail_count, num_checks;
  geg_src u_geg_src (.ref_clk, .fire, .pins);
  geg_top u_geg_top (.ref_clk, .rst_n, .init_pin(pins[0]), .init_msg, .nmi_pin(pins[1]),
    .ext_smi_pin(pins[2]), .io_smi_trap, .insn_boundary, .in_guest, .global_event_flag,
    .init_intercept, .init_redirect, .nmi_intercept, .smi_intercept, .intr_req,
    .vintr_req, .mgmt_lock_bit, .ctl_wr, .base_wr, .ctl_wdata,
    .mgmt_resume_instr, .apic_we, .apic_re, .apic_word, .apic_wdata, .irq_pend_set,
    .eoi_valid, .eoi_vector, .ack, .apic_rdata, .irq_valid, .irq_vector,
    .in_service, .exit_code, .action, .fetch_addr, .reinit_regs(), .mem_ctl_notify(),
    .gp_fault, .mgmt_mode_control_reg, .mgmt_mode_base_reg, .in_mgmt_mode,
    .guest_ctx_smi, .mgmt_memory_region, .intr_take, .vintr_take, .pend_flags);
  always #2 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Boundary or trap pulse, then catch the decision pulse
  task automatic bnd(input logic b, input logic t);
    ev = '0;
    insn_boundary = b;
    io_smi_trap = t;
    repeat (3) begin
      cyc(1);
      insn_boundary = 1'b0;
      io_smi_trap = 1'b0;
      if ({exit_code, action} !== 5'h0) ev = {27'h0, exit_code, action};
    end
  endtask
  task automatic apic(input logic we, input logic [2:0] w, input logic [31:0] d);
    apic_we = we;
    apic_re = ~we;
    apic_word = w;
    apic_wdata = d;
    cyc(1);
    ev = apic_rdata;
    {apic_we, apic_re} = 2'h0;
    cyc(2);
  endtask
  task automatic t_apic;
    apic(1'b0, 3'h7, 32'h0);
    chk("mask word 7", 32'hffffffff, ev);
    apic(1'b1, 3'h6, 32'hfffffeff);
    apic(1'b0, 3'h6, 32'h0);
    chk("mask word 6", 32'hfffffeff, ev);
    irq_pend_set[10] = 1'b1;
    irq_pend_set[200] = 1'b1;
    cyc(1);
    irq_pend_set = '0;
    cyc(3);
    chk("winner", 32'h0000000a, {24'h0, irq_vector});
    eoi_vector = 8'h0a;
    eoi_valid = 1'b1;
    cyc(1);
    eoi_valid = 1'b0;
    cyc(3);
    chk("irq_valid", 32'h0, {31'h0, irq_valid});
    apic(1'b1, 3'h6, 32'hffffffff);
    chk("unmasked winner", 32'h000000c8, {24'h0, irq_vector});
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(1);
    chk("in_service 200", 32'h1, {31'h0, in_service[200]});
    chk("irq_valid after ack", 32'h0, {31'h0, irq_valid});
    eoi_vector = 8'hc8;
    eoi_valid = 1'b1;
    cyc(1);
    eoi_valid = 1'b0;
    chk("in_service 200", 32'h0, {31'h0, in_service[200]});
  endtask
  task automatic t_init;
    in_guest = 1'b1;
    init_msg = 1'b1;
    cyc(1);
    init_msg = 1'b0;
    bnd(1'b1, 1'b0);
    chk("held init", 32'h0, ev);
    global_event_flag = 1'b1;
    init_intercept = 1'b1;
    bnd(1'b1, 1'b0);
    chk("init exit", {27'h0, GEG_EXIT_INIT, GEG_ACT_NONE}, ev);
    chk("pend_flags", 32'h1, {29'h0, pend_flags});
    init_intercept = 1'b0;
    init_redirect = 1'b1;
    bnd(1'b1, 1'b0);
    chk("redirect", {27'h0, GEG_EXIT_NONE, GEG_ACT_SECEXC}, ev);
    chk("pend_flags", 32'h0, {29'h0, pend_flags});
    init_redirect = 1'b0;
    fire = 3'h1;
    cyc(3);
    fire = 3'h0;
    cyc(4);
    bnd(1'b1, 1'b0);
    chk("pin init", {27'h0, GEG_EXIT_NONE, GEG_ACT_INIT}, ev);
    chk("fetch_addr", 32'h0ffffff0, fetch_addr);
  endtask
  task automatic t_nmi;
    global_event_flag = 1'b0;
    fire = 3'h2;
    cyc(3);
    fire = 3'h0;
    bnd(1'b1, 1'b0);
    chk("held nmi", 32'h0, ev);
    chk("pend_flags", 32'h2, {29'h0, pend_flags});
    global_event_flag = 1'b1;
    nmi_intercept = 1'b1;
    bnd(1'b1, 1'b0);
    chk("nmi exit", {27'h0, GEG_EXIT_NMI, GEG_ACT_NONE}, ev);
    chk("pend_flags", 32'h2, {29'h0, pend_flags});
    nmi_intercept = 1'b0;
    bnd(1'b1, 1'b0);
    chk("nmi taken", {27'h0, GEG_EXIT_NONE, GEG_ACT_NMI}, ev);
    chk("pend_flags", 32'h0, {29'h0, pend_flags});
  endtask
  task automatic t_intr;
    intr_req = 1'b1;
    vintr_req = 1'b1;
    cyc(1);
    chk("intr_take", 32'h1, {31'h0, intr_take});
    chk("vintr_take", 32'h0, {31'h0, vintr_take});
    intr_req = 1'b0;
    cyc(1);
    chk("vintr_take", 32'h1, {31'h0, vintr_take});
    global_event_flag = 1'b0;
    cyc(1);
    chk("vintr_take", 32'h0, {31'h0, vintr_take});
    vintr_req = 1'b0;
    global_event_flag = 1'b1;
    cyc(1);
  endtask
  task automatic t_lock;
    ctl_wdata = 32'h1;
    ctl_wr = 1'b1;
    base_wr = 1'b1;
    cyc(1);
    mgmt_lock_bit = 1'b1;
    ctl_wdata = 32'h2;
    cyc(1);
    ctl_wr = 1'b0;
    base_wr = 1'b0;
    chk("gp_fault", 32'h1, {31'h0, gp_fault});
    cyc(1);
    chk("control reg", 32'h1, mgmt_mode_control_reg);
    chk("base reg", 32'h1, mgmt_mode_base_reg);
    chk("gp_fault", 32'h0, {31'h0, gp_fault});
  endtask
  task automatic t_smi;
    global_event_flag = 1'b0;
    bnd(1'b0, 1'b1);
    chk("lost trap", 32'h0, ev);
    global_event_flag = 1'b1;
    smi_intercept = 1'b1;
    bnd(1'b0, 1'b1);
    chk("trap exit", {27'h0, GEG_EXIT_SMI, GEG_ACT_NONE}, ev);
    smi_intercept = 1'b0;
    global_event_flag = 1'b0;
    fire = 3'h4;
    cyc(3);
    fire = 3'h0;
    bnd(1'b1, 1'b0);
    chk("pend_flags", 32'h4, {29'h0, pend_flags});
    global_event_flag = 1'b1;
    bnd(1'b0, 1'b0);
    chk("flag rise", {27'h0, GEG_EXIT_NONE, GEG_ACT_SMI}, ev);
    chk("in_mgmt_mode", 32'h1, {31'h0, in_mgmt_mode});
    chk("guest_ctx_smi", 32'h1, {31'h0, guest_ctx_smi});
    chk("region mapped", 32'h1, {31'h0, mgmt_memory_region});
    mgmt_resume_instr = 1'b1;
    cyc(1);
    mgmt_resume_instr = 1'b0;
    chk("region unmapped", 32'h0, {31'h0, mgmt_memory_region});
    chk("guest_ctx_smi", 32'h0, {31'h0, guest_ctx_smi});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {ref_clk, rst_n, init_msg, io_smi_trap, insn_boundary, in_guest, global_event_flag} = '0;
    {init_intercept, init_redirect, nmi_intercept, smi_intercept, mgmt_lock_bit} = '0;
    {ctl_wr, apic_we, apic_re, eoi_valid, fire, apic_word, eoi_vector} = '0;
    {ctl_wdata, apic_wdata, irq_pend_set} = '0;
    {intr_req, vintr_req, base_wr, mgmt_resume_instr, ack} = '0;
    fail_count = 0;
    num_checks = 0;
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    t_apic;
    t_init;
    t_nmi;
    t_intr;
    t_lock;
    t_smi;
    test_done;
  end
endmodule
`default_nettype wire
